/* core/ramc_regs.vh */
// Register offsets, field positions, reset values and timing counts.
`ifndef RAMC_REGS_VH
`define RAMC_REGS_VH
`define RAMC_OFF_PANEL 12'h000
`define RAMC_OFF_CTRL 12'h004
`define RAMC_OFF_STAT 12'h008
`define RAMC_OFF_TERM 12'h00c
`define RAMC_KEY_LOCAL 2'h0
`define RAMC_KEY_LOCAL_DIS 2'h1
`define RAMC_KEY_REMOTE 2'h2
`define RAMC_KEY_REMOTE_DIS 2'h3
`define RAMC_CTRL_LOCAL_REQ 0
`define RAMC_CTRL_TERM_REQ 1
`define RAMC_CTRL_RESET 32'h00000000
`define RAMC_TERM_NS 1000
`define RAMC_CLK_NS 4
`define RAMC_TERM_CYC ((`RAMC_TERM_NS + `RAMC_CLK_NS - 1) / `RAMC_CLK_NS)
`endif

/* core/ramc_sync.v */
// Two-stage synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/10ps
module ramc_sync #(
  parameter W = 4
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // ramc_sync

/* core/ramc_top.v */
// Keyswitch access mode control with modem call answering, APB slave.
`timescale 1ns/10ps
`include "ramc_regs.vh"
// Notes on behaviour
// - Panel register sampled at reset release and on every idle pass.
// - Keyswitch position appears in bits 1:0 of the panel register.
// - Local: local console with command and program modes; remote off.
// - Local disable: local operator terminal only; no command mode.
// - Remote: remote port on with command and program modes.
// - Remote: local console starts off, enabled on remote request.
// - Remote disable: remote is operator terminal, program mode only.
// - Remote disable: local copy on; local keyboard on only on request.
// - Remote lamp lit in remote and remote disable only.
// - Remote position asserts DTR so the modem may answer.
// - Carrier loss starts termination and drops DTR.
// - After termination DTR returns only if still a remote position.
module ramc_top (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [1:0] keyswitch_i,
  input wire idle_loop_i,
  input wire modem_cd_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg local_console_en_o,
  output reg local_kbd_en_o,
  output reg local_copy_en_o,
  output reg remote_port_en_o,
  output reg command_mode_en_o,
  output reg program_mode_en_o,
  output reg remote_lamp_o,
  output reg modem_dtr_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ANSWER = 2'd1;
  localparam ST_TERM = 2'd2;
  localparam integer TERM_CYC_I = `RAMC_TERM_CYC;
  localparam [15:0] TERM_CYC = TERM_CYC_I[15:0];

  function is_remote;
    input [1:0] key;
    begin
      is_remote = (key == `RAMC_KEY_REMOTE) ||
                  (key == `RAMC_KEY_REMOTE_DIS);
    end
  endfunction

  reg [1:0] panel_q;
  reg sampled_q;
  reg [1:0] fill_q;
  reg [1:0] prev_key_q;
  reg local_req_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] tcnt_q;
  reg cd_q;
  wire [1:0] key_w;
  wire idle_w;
  wire cd_w;
  wire acc_w;
  wire wr_w;
  wire rd_ok_w;
  wire req_w;

  ramc_sync #(
    .W(4)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({modem_cd_i, idle_loop_i, keyswitch_i}),
    .sync_o({cd_w, idle_w, key_w})
  );

  assign acc_w = psel && penable;
  assign pready = 1'b1;
  assign wr_w = acc_w && pwrite;
  assign rd_ok_w = (paddr == `RAMC_OFF_PANEL) ||
                   (paddr == `RAMC_OFF_CTRL) ||
                   (paddr == `RAMC_OFF_STAT) ||
                   (paddr == `RAMC_OFF_TERM);
  assign pslverr = acc_w && !rd_ok_w;

  // Panel register copy: taken once after reset, then on each idle pass.
  // The power-up sample waits until the synchroniser holds a real pin
  // value; otherwise its reset zeros would be taken as the key position.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      panel_q <= `RAMC_KEY_LOCAL;
      sampled_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      fill_q <= {fill_q[0], 1'b1};
      if ((fill_q[1] && !sampled_q) || idle_w) begin
        panel_q <= key_w;
        sampled_q <= 1'b1;
      end
    end
  end

  // Remote operator's request to open the local terminal. Cleared whenever
  // the position changes, so each remote entry starts with it closed.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev_key_q <= `RAMC_KEY_LOCAL;
      local_req_q <= 1'b0;
    end else begin
      prev_key_q <= panel_q;
      if (prev_key_q != panel_q) begin
        local_req_q <= 1'b0;
      end else if (wr_w && paddr == `RAMC_OFF_CTRL) begin
        local_req_q <= pwdata[`RAMC_CTRL_LOCAL_REQ];
      end
    end
  end

  // A stale request must not leak into the first cycle of a new position.
  assign req_w = local_req_q && (prev_key_q == panel_q);

  // Mode outputs decoded from the sampled position.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      local_console_en_o <= 1'b1;
      local_kbd_en_o <= 1'b1;
      local_copy_en_o <= 1'b0;
      remote_port_en_o <= 1'b0;
      command_mode_en_o <= 1'b1;
      program_mode_en_o <= 1'b1;
      remote_lamp_o <= 1'b0;
    end else begin
      remote_lamp_o <= is_remote(panel_q);
      case (panel_q)
        `RAMC_KEY_LOCAL: begin
          local_console_en_o <= 1'b1;
          local_kbd_en_o <= 1'b1;
          local_copy_en_o <= 1'b0;
          remote_port_en_o <= 1'b0;
          command_mode_en_o <= 1'b1;
          program_mode_en_o <= 1'b1;
        end
        `RAMC_KEY_LOCAL_DIS: begin
          local_console_en_o <= 1'b1;
          local_kbd_en_o <= 1'b1;
          local_copy_en_o <= 1'b0;
          remote_port_en_o <= 1'b0;
          command_mode_en_o <= 1'b0;
          program_mode_en_o <= 1'b1;
        end
        `RAMC_KEY_REMOTE: begin
          local_console_en_o <= req_w;
          local_kbd_en_o <= req_w;
          local_copy_en_o <= 1'b0;
          remote_port_en_o <= 1'b1;
          command_mode_en_o <= 1'b1;
          program_mode_en_o <= 1'b1;
        end
        default: begin
          local_console_en_o <= 1'b1;
          local_kbd_en_o <= req_w;
          local_copy_en_o <= 1'b1;
          remote_port_en_o <= 1'b1;
          command_mode_en_o <= 1'b0;
          program_mode_en_o <= 1'b1;
        end
      endcase
    end
  end

  // Call answering: DTR raised on entering remote, kept in either remote position, dropped on carrier loss.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (panel_q == `RAMC_KEY_REMOTE) begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        if (cd_q && !cd_w) begin
          state_d = ST_TERM;
        end else if (!is_remote(panel_q)) begin
          state_d = ST_IDLE;
        end
      end
      ST_TERM: begin
        if (tcnt_q == 16'h0001) begin
          state_d = is_remote(panel_q) ? ST_ANSWER : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      tcnt_q <= 16'h0000;
      cd_q <= 1'b0;
      modem_dtr_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cd_q <= cd_w;
      modem_dtr_o <= (state_d == ST_ANSWER);
      if (state_q != ST_TERM && state_d == ST_TERM) begin
        tcnt_q <= TERM_CYC;
      end else if (tcnt_q != 16'h0000) begin
        tcnt_q <= tcnt_q - 16'h0001;
      end
    end
  end

  // Read data is registered; unmapped reads return zero with an error.
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `RAMC_OFF_PANEL) begin
        prdata <= {30'h00000000, panel_q};
      end else if (paddr == `RAMC_OFF_CTRL) begin
        prdata <= {31'h00000000, local_req_q};
      end else if (paddr == `RAMC_OFF_STAT) begin
        prdata <= {24'h000000, modem_dtr_o, remote_lamp_o,
                   program_mode_en_o, command_mode_en_o, remote_port_en_o,
                   local_copy_en_o, local_kbd_en_o, local_console_en_o};
      end else if (paddr == `RAMC_OFF_TERM) begin
        prdata <= {14'h0000, state_q, tcnt_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule // ramc_top

/* dv/ramc_asserts.sv */
// Checker for the access mode outputs and call answering.
`timescale 1ns/10ps
`include "ramc_regs.vh"
module ramc_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] keyswitch_i,
  input wire logic idle_loop_i,
  input wire logic modem_cd_i,
  input wire logic local_console_en_o,
  input wire logic local_copy_en_o,
  input wire logic remote_port_en_o,
  input wire logic command_mode_en_o,
  input wire logic program_mode_en_o,
  input wire logic remote_lamp_o,
  input wire logic modem_dtr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Eight idle passes cover the synchroniser and the panel sample.
  sequence held_s(logic [1:0] k);
    (keyswitch_i == k && idle_loop_i)[*8];
  endsequence
  sequence cd_lost_s;
    $fell(modem_cd_i) && modem_dtr_o;
  endsequence
  lamp_match_a: assert property (remote_lamp_o == remote_port_en_o)
    else $error("lamp differs from remote port");
  cmd_prog_a: assert property (command_mode_en_o |-> program_mode_en_o)
    else $error("command mode without program mode");
  key_local_a: assert property (held_s(`RAMC_KEY_LOCAL) |->
    command_mode_en_o && !remote_port_en_o && local_console_en_o)
    else $error("local position outputs wrong");
  key_ldis_a: assert property (held_s(`RAMC_KEY_LOCAL_DIS) |->
    !command_mode_en_o && !remote_port_en_o) else $error("panel lock wrong");
  key_remote_a: assert property (held_s(`RAMC_KEY_REMOTE) |->
    remote_port_en_o && command_mode_en_o && !local_copy_en_o)
    else $error("remote position outputs wrong");
  key_rdis_a: assert property (held_s(`RAMC_KEY_REMOTE_DIS) |->
    local_copy_en_o && remote_port_en_o && !command_mode_en_o)
    else $error("remote disable outputs wrong");
  dtr_drop_a: assert property (cd_lost_s |-> ##[1:4] !modem_dtr_o)
    else $error("ready kept after carrier loss");
  dtr_remote_a: assert property ($rose(modem_dtr_o) |-> remote_lamp_o)
    else $error("ready raised outside remote positions");
endmodule // ramc_asserts
bind ramc_top ramc_asserts ramc_asserts_i (.*);

/* dv/ramc_modem.sv */
// Behavioural modem: raises carrier a set delay after ready is seen.
`timescale 1ns/10ps
module ramc_modem (
  input wire logic ref_clk_i,
  input wire logic dtr_i,
  input wire logic hang_i,
  input wire logic [7:0] delay_i,
  output logic cd_o = 1'b0
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge ref_clk_i) begin
    if (!dtr_i || hang_i) begin
      cnt_q <= 8'h00;
      cd_o <= 1'b0;
    end else if (cnt_q >= delay_i) begin
      cd_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // ramc_modem

/* dv/tb_top.sv */
// Self-checking bench for the keyswitch access mode controller.
`timescale 1ns/10ps
`include "ramc_regs.vh"
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] key_q = 2'h0;
  logic idle_q = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hang = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cd;
  logic [7:0] dly = 8'h05;
  logic [1:0] kr;
  wire [7:0] outs;
  int mismatches = 0, n_tests = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  ramc_top ramc_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .keyswitch_i(key_q), .idle_loop_i(idle_q), .modem_cd_i(cd),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_console_en_o(outs[0]), .local_kbd_en_o(outs[1]),
    .local_copy_en_o(outs[2]), .remote_port_en_o(outs[3]),
    .command_mode_en_o(outs[4]), .program_mode_en_o(outs[5]),
    .remote_lamp_o(outs[6]), .modem_dtr_o(outs[7]));
  ramc_modem ramc_modem_i (.ref_clk_i(ref_clk_i), .dtr_i(outs[7]),
    .hang_i(hang), .delay_i(dly), .cd_o(cd));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic key(input logic [1:0] k);
    @(posedge ref_clk_i);
    key_q <= k;
    repeat (10) @(posedge ref_clk_i);
  endtask
  function automatic logic [6:0] exp_mode(input logic [1:0] k);
    case (k)
      2'h0: return 7'h33;
      2'h1: return 7'h23;
      2'h2: return 7'h78;
      default: return 7'h6d;
    endcase
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h05e97e6c));
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(outs[6:0], 7'h33);
    for (int k = 0; k < 4; k++) begin
      key(k[1:0]);
      chk(outs[6:0], exp_mode(k[1:0]));
      apb(1'b0, `RAMC_OFF_STAT, 32'h0);
      chk(rd[6:0], exp_mode(k[1:0]));
      apb(1'b0, `RAMC_OFF_PANEL, 32'h0);
      chk(rd[1:0], k[1:0]);
    end
    $display("mode table test done");
    idle_q <= 1'b0;
    key(2'h2);
    chk(outs[6:0], 7'h6d);
    idle_q <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk(outs[6:0], 7'h78);
    chk(outs[7], 1'b1);
    apb(1'b1, `RAMC_OFF_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk(outs[0], 1'b1);
    apb(1'b0, `RAMC_OFF_CTRL, 32'h0);
    chk(rd[0], 1'b1);
    key(2'h3);
    chk(outs[1], 1'b0);
    apb(1'b1, `RAMC_OFF_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk(outs[1], 1'b1);
    apb(1'b1, `RAMC_OFF_CTRL, 32'h0);
    apb(1'b0, 12'h010 + 12'($urandom_range(0, 250) * 4), 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("request test done");
    for (int i = 0; i < 2; i++) begin
      dly <= 8'($urandom_range(1, 40));
      repeat (50) @(posedge ref_clk_i);
      hang <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      chk(outs[7], 1'b0);
      apb(1'b0, `RAMC_OFF_TERM, 32'h0);
      chk(rd[17:16], 2'h2);
      hang <= 1'b0;
      key(i == 0 ? 2'h3 : 2'h0);
      repeat (250) @(posedge ref_clk_i);
      chk(outs[7], i == 0);
    end
    $display("answer test done");
    repeat (8) begin
      kr = 2'($urandom);
      key(kr);
      chk(outs[6:0], exp_mode(kr));
    end
    $display("random test done");
    final_report;
  end
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    mismatches++;
    final_report;
  end
endmodule // tb_top
